//--- i2c_host_model.sv
`timescale 1ns/1ps
module i2c_host_model (
   // clock
   input wire logic mclk,
   // resolved bus
   input wire logic scl,
   input wire logic sda,
   // open-drain pulls
   output logic     scl_low,
   output logic     sda_low
);
   import i2c_regs_pkg::*;
   localparam int HALF = 8;
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask : tick
   task automatic scl_rise();
      int guard;
      guard = 0;
      scl_low = 1'b0;
      while (scl !== 1'b1 && guard < 2000) begin
         tick(1);
         guard++;
      end
      tick(HALF);
   endtask : scl_rise
   task automatic scl_fall();
      scl_low = 1'b1;
      tick(2);
   endtask : scl_fall
   task automatic start();
      sda_low = 1'b0;
      tick(HALF);
      scl_rise();
      sda_low = 1'b1;
      tick(HALF);
      scl_fall();
   endtask : start
   task automatic stop();
      sda_low = 1'b1;
      tick(HALF);
      scl_rise();
      sda_low = 1'b0;
      tick(HALF);
   endtask : stop
   task automatic put_bit(input logic b);
      sda_low = ~b;
      tick(HALF);
      scl_rise();
      scl_fall();
   endtask : put_bit
   task automatic get_bit(output logic b);
      sda_low = 1'b0;
      tick(HALF);
      scl_rise();
      b = sda;
      scl_fall();
   endtask : get_bit
   task automatic send_byte(input byte_t d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) put_bit(d[i]);
      get_bit(b);
      ack = ~b;
   endtask : send_byte
   task automatic recv_byte(input logic ack, output byte_t d);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         get_bit(b);
         d[i] = b;
      end
      put_bit(~ack);
   endtask : recv_byte
endmodule : i2c_host_model

//--- i2c_regs_pkg.sv
// What this block does
// RULE1 - acknowledge every write data byte, accept any count
// RULE2 - host ends every write with a stop
// RULE3 - offsetless read starts at 00h or last+1
// RULE4 - read starts at previously written offset
// RULE5 - read bytes are shifted out MSB first
// RULE6 - sample host ack, send next byte on ack
// RULE7 - on host nack release data, wait for stop
// RULE8 - combined read: write addr, offset, restart, read
// RULE9 - ack read address, return from written offset
// RULE10 - address, offset, stop only loads the pointer
// RULE11 - offset is one MSB-first byte, acknowledged
// RULE12 - acknowledge own address for read or write
// RULE13 - after power-up reads start at 00h, incrementing
// RULE14 - pointer increments per sent byte, ack or not
// RULE15 - host opens write with start, address, zero
// RULE16 - tuning registers 70h-79h reachable over RAP
// RULE17 - serial register 50h on RAP 10h/20h
// RULE18 - host leaves unmapped offsets alone
// RULE19 - tuning register defaults come from OTP
// RULE20 - hardware-updated fields change without bus writes
// RULE21 - respond only to target address 3Eh
// RULE22 - nack foreign address, ignore the transaction
// RULE23 - write data stored at pointer, pointer advances
package i2c_regs_pkg;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam int NUM_REGS = 21;
   localparam int NUM_OTP  = 7;
   typedef logic [7:0] byte_t;
   typedef logic [NUM_REGS-1:0][7:0] reg_image_t;
   typedef logic [NUM_OTP-1:0][7:0] otp_t;
   localparam byte_t REG_OFFS [NUM_REGS] = '{
      8'h00, 8'h40, 8'h50, 8'h60, 8'h70, 8'h71, 8'h72,
      8'h73, 8'h77, 8'h78, 8'h79, 8'ha3, 8'ha4, 8'hb0,
      8'hb2, 8'hb3, 8'hb4, 8'hb5, 8'hb6, 8'hb7, 8'hf5};
   localparam logic [4:0] IDX_GPIO0      = 5'h00;
   localparam logic [4:0] IDX_GPIO1      = 5'h01;
   localparam logic [4:0] IDX_TUNE_FIRST = 5'h04;
   localparam logic [4:0] IDX_EVT1       = 5'h0b;
   localparam logic [4:0] IDX_EVT2       = 5'h0c;
   localparam logic [4:0] IDX_REV        = 5'h0d;
   localparam int    GPIO_STATUS_BIT = 4;
   localparam byte_t REG_RESET       = 8'h00;
   localparam byte_t BYTE_ZERO       = 8'h00;
   localparam byte_t PTR_RESET       = 8'h00;
   localparam byte_t PTR_STEP        = 8'h01;

   // ----------------------------------------
   // i2c framing
   // ----------------------------------------
   localparam logic [6:0] TARGET_ADDR = 7'h3e;
   localparam logic [3:0] BIT_ZERO    = 4'h0;
   localparam logic [3:0] BIT_ONE     = 4'h1;
   localparam logic [3:0] BIT_LAST    = 4'h8;
   localparam logic [2:0] TOP_BIT     = 3'h7;

   // ----------------------------------------
   // register access protocol mapping
   // ----------------------------------------
   localparam byte_t RAP_TUNE_WR   = 8'h30;
   localparam byte_t RAP_TUNE_SPAN = 8'h0a;
   localparam byte_t TUNE_OFF      = 8'h70;
   localparam byte_t RAP_SERIAL_WR = 8'h10;
   localparam byte_t RAP_SERIAL_RD = 8'h20;
   localparam byte_t SERIAL_OFF    = 8'h50;
   localparam byte_t RAP_UNMAPPED  = 8'hff;

   // ----------------------------------------
   // write buffer and carriers
   // ----------------------------------------
   localparam int FIFO_WIDTH = 16;
   localparam int FIFO_DEPTH = 32;
   typedef struct packed {
      byte_t addr;
      byte_t data;
   } wr_entry_s;
   typedef struct packed {
      logic  valid;
      logic  write;
      byte_t addr;
      byte_t wdata;
   } rap_req_s;
   typedef struct packed {
      logic       hit;
      logic [4:0] idx;
   } reg_sel_s;

endpackage : i2c_regs_pkg

//--- i2c_target.sv
`timescale 1ns/1ps
module i2c_target #(
   parameter i2c_regs_pkg::byte_t REV_CODE = 8'h01 // arbitrary value
) (
   // clock and reset
   input  wire logic                     mclk,
   input  wire logic                     rst_n,
   // i2c pins
   input  wire logic                     scl_i,
   output logic                          scl_o,
   output logic                          scl_oe,
   input  wire logic                     sda_i,
   output logic                          sda_o,
   output logic                          sda_oe,
   // hardware status
   input  wire logic                     gpio_zero_i,
   input  wire logic                     gpio_one_i,
   input  wire i2c_regs_pkg::byte_t      evt_first_set,
   input  wire i2c_regs_pkg::byte_t      evt_second_set,
   input  wire i2c_regs_pkg::otp_t       otp_defaults,
   // register access protocol port
   input  wire i2c_regs_pkg::rap_req_s   rap_req,
   output logic                          rap_done,
   output i2c_regs_pkg::byte_t           rap_rdata,
   // register contents
   output i2c_regs_pkg::reg_image_t      reg_image
);
   import i2c_regs_pkg::*;

   typedef enum logic [10:0] {
      ST_IDLE     = 11'b000_0000_0001,
      ST_ADDR     = 11'b000_0000_0010,
      ST_ADDR_ACK = 11'b000_0000_0100,
      ST_OFFSET   = 11'b000_0000_1000,
      ST_OFF_ACK  = 11'b000_0001_0000,
      ST_WDATA    = 11'b000_0010_0000,
      ST_WPUSH    = 11'b000_0100_0000,
      ST_WACK     = 11'b000_1000_0000,
      ST_RDATA    = 11'b001_0000_0000,
      ST_RACK     = 11'b010_0000_0000,
      ST_WAIT     = 11'b100_0000_0000
   } i2c_state_e;

   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   function automatic reg_sel_s off2idx(byte_t off);
      reg_sel_s s;
      s = '0;
      for (int i = 0; i < NUM_REGS; i++) begin
         if (REG_OFFS[i] == off) begin
            s.hit = 1'b1;
            s.idx = 5'(i);
         end
      end
      return s;
   endfunction : off2idx

   function automatic byte_t reg_read(reg_image_t img, byte_t off);
      reg_sel_s s;
      s = off2idx(off);
      return s.hit ? img[s.idx] : BYTE_ZERO;
   endfunction : reg_read

   function automatic reg_sel_s rap_map(byte_t a, logic wr);
      byte_t off;
      off = RAP_UNMAPPED;
      if (wr && a >= RAP_TUNE_WR && a < RAP_TUNE_WR + RAP_TUNE_SPAN) begin
         off = TUNE_OFF + (a - RAP_TUNE_WR); // RULE16
      end else if (!wr && a < RAP_TUNE_SPAN) begin
         off = TUNE_OFF + a; // RULE16
      end else if (wr ? (a == RAP_SERIAL_WR) : (a == RAP_SERIAL_RD)) begin
         off = SERIAL_OFF; // RULE17
      end
      return off2idx(off);
   endfunction : rap_map

   function automatic byte_t reg_wr(logic [4:0] idx, byte_t old, byte_t w);
      if (idx == IDX_EVT1 || idx == IDX_EVT2) return old & ~w;
      if (idx == IDX_REV) return old;
      return w;
   endfunction : reg_wr

   // ----------------------------------------
   // state
   // ----------------------------------------
   i2c_state_e state_q, state_d;
   logic [3:0] bit_q, bit_d;
   byte_t      shift_q, shift_d;
   byte_t      tx_q, tx_d;
   byte_t      ptr_q, ptr_d;
   logic       rw_q, rw_d;
   logic       sda_oe_q, sda_oe_d;
   logic       scl_oe_q, scl_oe_d;
   logic       scl_s1_q, scl_s2_q, scl_s3_q;
   logic       sda_s1_q, sda_s2_q, sda_s3_q;
   logic       gp0_s1_q, gp0_s2_q;
   logic       gp1_s1_q, gp1_s2_q;
   reg_image_t regs_q, regs_d, rst_image;
   logic       rap_done_q;
   byte_t      rap_rdata_q;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
         {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
      end else begin
         {scl_s1_q, scl_s2_q, scl_s3_q} <= {scl_i, scl_s1_q, scl_s2_q};
         {sda_s1_q, sda_s2_q, sda_s3_q} <= {sda_i, sda_s1_q, sda_s2_q};
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         {gp0_s1_q, gp0_s2_q} <= 2'h0;
         {gp1_s1_q, gp1_s2_q} <= 2'h0;
      end else begin
         {gp0_s1_q, gp0_s2_q} <= {gpio_zero_i, gp0_s1_q};
         {gp1_s1_q, gp1_s2_q} <= {gpio_one_i, gp1_s1_q};
      end
   end

   // ----------------------------------------
   // bus event decode
   // ----------------------------------------
   wire scl_rise  = scl_s2_q & ~scl_s3_q;
   wire scl_fall  = ~scl_s2_q & scl_s3_q;
   wire scl_high  = scl_s2_q & scl_s3_q;
   wire start_det = scl_high & sda_s3_q & ~sda_s2_q;
   wire stop_det  = scl_high & ~sda_s3_q & sda_s2_q;
   wire addr_hit  = (shift_q[7:1] == TARGET_ADDR); // RULE21
   wire last_bit  = (bit_q == BIT_LAST);
   wire tx_bit    = tx_q[TOP_BIT - bit_q[2:0]]; // RULE5

   // ----------------------------------------
   // write buffer
   // ----------------------------------------
   wr_entry_s fill_entry, drain_entry;
   logic      fill_ready, drain_valid;
   wire       fill_valid  = (state_q == ST_WPUSH);
   wire       drain_ready = ~(rap_req.valid & rap_req.write);
   wire       drain_fire  = drain_valid & drain_ready;
   assign fill_entry = '{addr: ptr_q, data: shift_q}; // RULE23

   i2c_wr_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_wr_fifo (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .in_valid  (fill_valid),
      .in_ready  (fill_ready),
      .in_data   (fill_entry),
      .out_valid (drain_valid),
      .out_ready (drain_ready),
      .out_data  (drain_entry)
   );

   // ----------------------------------------
   // register read and write decode
   // ----------------------------------------
   wire reg_sel_s drain_sel  = off2idx(drain_entry.addr);
   wire reg_sel_s rap_wr_sel = rap_map(rap_req.addr, 1'b1);
   wire reg_sel_s rap_rd_sel = rap_map(rap_req.addr, 1'b0);
   wire rap_wr_fire = rap_req.valid & rap_req.write & rap_wr_sel.hit;
   wire byte_t rap_rd_val = rap_rd_sel.hit ? regs_q[rap_rd_sel.idx] : BYTE_ZERO;

   always_comb begin
      rst_image = '0;
      for (int i = 0; i < NUM_REGS; i++) begin
         rst_image[i] = REG_RESET;
      end
      for (int k = 0; k < NUM_OTP; k++) begin
         rst_image[IDX_TUNE_FIRST + 5'(k)] = otp_defaults[k]; // RULE19
      end
      rst_image[IDX_REV] = REV_CODE;
   end

   always_comb begin
      regs_d = regs_q;
      if (drain_fire && drain_sel.hit) begin
         regs_d[drain_sel.idx] = reg_wr(drain_sel.idx, regs_q[drain_sel.idx], drain_entry.data); // RULE23
      end
      if (rap_wr_fire) begin
         regs_d[rap_wr_sel.idx] = reg_wr(rap_wr_sel.idx, regs_q[rap_wr_sel.idx], rap_req.wdata); // RULE16
      end
      regs_d[IDX_GPIO0][GPIO_STATUS_BIT] = gp0_s2_q; // RULE20
      regs_d[IDX_GPIO1][GPIO_STATUS_BIT] = gp1_s2_q; // RULE20
      regs_d[IDX_EVT1] = regs_d[IDX_EVT1] | evt_first_set; // RULE20
      regs_d[IDX_EVT2] = regs_d[IDX_EVT2] | evt_second_set; // RULE20
      regs_d[IDX_REV] = REV_CODE;
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         regs_q <= rst_image; // RULE19
      end else begin
         regs_q <= regs_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rap_done_q  <= 1'b0;
         rap_rdata_q <= BYTE_ZERO;
      end else begin
         rap_done_q  <= rap_req.valid;
         rap_rdata_q <= rap_rd_val; // RULE17
      end
   end

   // ----------------------------------------
   // i2c target sequencer
   // ----------------------------------------
   always_comb begin
      state_d  = state_q;
      bit_d    = bit_q;
      shift_d  = shift_q;
      tx_d     = tx_q;
      ptr_d    = ptr_q;
      rw_d     = rw_q;
      sda_oe_d = sda_oe_q;
      scl_oe_d = 1'b0;
      if (stop_det) begin
         state_d  = ST_IDLE; // RULE7
         sda_oe_d = 1'b0;
      end else if (start_det) begin
         state_d  = ST_ADDR; // RULE9
         bit_d    = BIT_ZERO;
         sda_oe_d = 1'b0;
      end else begin
         case (state_q)
            ST_ADDR, ST_OFFSET, ST_WDATA: begin
               if (scl_rise) begin
                  shift_d = {shift_q[6:0], sda_s2_q}; // RULE11
                  bit_d   = bit_q + BIT_ONE;
               end else if (scl_fall && last_bit) begin
                  bit_d = BIT_ZERO;
                  if (state_q == ST_ADDR) begin
                     if (addr_hit) begin
                        state_d  = ST_ADDR_ACK; // RULE12
                        sda_oe_d = 1'b1;
                        rw_d     = shift_q[0];
                        tx_d     = reg_read(regs_q, ptr_q); // RULE3 RULE4
                     end else begin
                        state_d = ST_WAIT; // RULE22
                     end
                  end else if (state_q == ST_OFFSET) begin
                     ptr_d    = shift_q; // RULE10
                     state_d  = ST_OFF_ACK; // RULE11
                     sda_oe_d = 1'b1;
                  end else begin
                     state_d  = ST_WPUSH;
                     scl_oe_d = ~fill_ready;
                  end
               end
            end
            ST_WPUSH: begin
               if (fill_ready) begin
                  ptr_d    = ptr_q + PTR_STEP; // RULE23
                  sda_oe_d = 1'b1; // RULE1
                  scl_oe_d = scl_oe_q; // ack settles before clock release
                  state_d  = ST_WACK;
               end else begin
                  scl_oe_d = 1'b1;
               end
            end
            ST_ADDR_ACK, ST_OFF_ACK, ST_WACK: begin
               if (scl_fall) begin
                  bit_d = BIT_ZERO;
                  if (state_q == ST_ADDR_ACK && rw_q) begin
                     state_d  = ST_RDATA; // RULE9
                     sda_oe_d = ~tx_q[TOP_BIT]; // RULE5
                  end else begin
                     state_d  = (state_q == ST_ADDR_ACK) ? ST_OFFSET : ST_WDATA; // RULE1
                     sda_oe_d = 1'b0;
                  end
               end
            end
            ST_RDATA: begin
               if (scl_rise) begin
                  bit_d = bit_q + BIT_ONE;
               end else if (scl_fall) begin
                  if (last_bit) begin
                     sda_oe_d = 1'b0;
                     ptr_d    = ptr_q + PTR_STEP; // RULE14 RULE13
                     state_d  = ST_RACK;
                  end else begin
                     sda_oe_d = ~tx_bit; // RULE5
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  if (sda_s2_q) begin
                     state_d = ST_WAIT; // RULE7
                  end else begin
                     tx_d = reg_read(regs_q, ptr_q); // RULE6
                  end
               end else if (scl_fall) begin
                  bit_d    = BIT_ZERO;
                  state_d  = ST_RDATA; // RULE6
                  sda_oe_d = ~tx_q[TOP_BIT];
               end
            end
            default: begin
               state_d = state_q;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_q  <= ST_IDLE;
         bit_q    <= BIT_ZERO;
         shift_q  <= BYTE_ZERO;
         tx_q     <= BYTE_ZERO;
         ptr_q    <= PTR_RESET; // RULE13
         rw_q     <= 1'b0;
         sda_oe_q <= 1'b0;
         scl_oe_q <= 1'b0;
      end else begin
         state_q  <= state_d;
         bit_q    <= bit_d;
         shift_q  <= shift_d;
         tx_q     <= tx_d;
         ptr_q    <= ptr_d;
         rw_q     <= rw_d;
         sda_oe_q <= sda_oe_d;
         scl_oe_q <= scl_oe_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign scl_o     = 1'b0;
   assign sda_o     = 1'b0;
   assign scl_oe    = scl_oe_q;
   assign sda_oe    = sda_oe_q;
   assign rap_done  = rap_done_q;
   assign rap_rdata = rap_rdata_q;
   assign reg_image = regs_q;

endmodule : i2c_target

//--- i2c_target_asserts.sv
`timescale 1ns/1ps
module i2c_target_asserts (
   // clock and reset
   input wire logic                     mclk,
   input wire logic                     rst_n,
   // pins
   input wire logic                     scl_i,
   input wire logic                     sda_oe,
   // status and side port
   input wire logic                     gpio_zero_i,
   input wire i2c_regs_pkg::byte_t      evt_first_set,
   input wire i2c_regs_pkg::otp_t       otp_defaults,
   input wire i2c_regs_pkg::rap_req_s   rap_req,
   input wire logic                     rap_done,
   input wire i2c_regs_pkg::byte_t      rap_rdata,
   input wire i2c_regs_pkg::reg_image_t reg_image
);
   import i2c_regs_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------
   // sequences
   // ----------------------------------------
   sequence s_rap(logic w, byte_t a);
      rap_req.valid && rap_req.write == w && rap_req.addr == a;
   endsequence
   sequence s_gpio_steady;
      $stable(gpio_zero_i) [*5];
   endsequence
   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_done_after_req: assert property (rap_req.valid |=> rap_done)
      else $error("side port request got no done");
   a_done_needs_req: assert property (rap_done |-> $past(rap_req.valid))
      else $error("done without request");
   a_tune_write: assert property (s_rap(1'b1, 8'h30) |=> reg_image[4] == $past(rap_req.wdata))
      else $error("tuning write not stored");
   a_tune_read: assert property (s_rap(1'b0, 8'h09) |=> rap_rdata == $past(reg_image[10]))
      else $error("tuning read wrong");
   a_serial_write: assert property (s_rap(1'b1, 8'h10) |=> reg_image[2] == $past(rap_req.wdata))
      else $error("serial write not stored");
   a_serial_read: assert property (s_rap(1'b0, 8'h20) |=> rap_rdata == $past(reg_image[2]))
      else $error("serial read wrong");
   a_otp_loaded: assert property ($rose(rst_n) |-> reg_image[4] == otp_defaults[0] && reg_image[10] == otp_defaults[6])
      else $error("tuning default not from otp");
   a_gpio_follow: assert property (s_gpio_steady |-> reg_image[IDX_GPIO0][GPIO_STATUS_BIT] == gpio_zero_i)
      else $error("gpio status bit stale");
   a_event_set: assert property (evt_first_set[0] |-> ##[1:2] reg_image[IDX_EVT1][0])
      else $error("event flag not set");
   a_sda_in_low: assert property ($changed(sda_oe) |-> !scl_i)
      else $error("data line moved while clock high");
endmodule : i2c_target_asserts

bind i2c_target i2c_target_asserts u_asserts (
   .mclk          (mclk),
   .rst_n         (rst_n),
   .scl_i         (scl_i),
   .sda_oe        (sda_oe),
   .gpio_zero_i   (gpio_zero_i),
   .evt_first_set (evt_first_set),
   .otp_defaults  (otp_defaults),
   .rap_req       (rap_req),
   .rap_done      (rap_done),
   .rap_rdata     (rap_rdata),
   .reg_image     (reg_image)
);

//--- i2c_wr_fifo.sv
`timescale 1ns/1ps
module i2c_wr_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             rst_n,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0]   CNT_FULL = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] PTR_ONE  = {{(AW-1){1'b0}}, 1'b1};

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   wire              push = in_valid & in_ready;
   wire              pop  = out_valid & out_ready;

   assign in_ready  = (cnt_q != CNT_FULL);
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];

   // ----------------------------------------
   // pointers and storage
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wr_q <= wr_q + PTR_ONE;
         if (pop) rd_q <= rd_q + PTR_ONE;
         if (push && !pop) cnt_q <= cnt_q + 1'b1;
         else if (pop && !push) cnt_q <= cnt_q - 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (push) mem_q[wr_q] <= in_data;
   end

endmodule : i2c_wr_fifo

//--- tb_i2c_target_register_access.sv
`timescale 1ns/1ps
module tb_i2c_target_register_access;
   import i2c_regs_pkg::*;
   localparam byte_t REV = 8'h5c; // arbitrary value
   logic                  mclk;
   logic                  rst_n;
   logic                  gpio_zero_i;
   byte_t                 evt_first_set;
   otp_t                  otp_defaults;
   rap_req_s              rap_req;
   logic                  rap_done;
   byte_t                 rap_rdata;
   reg_image_t            reg_image;
   reg_image_t            img;
   logic                  scl_oe;
   logic                  sda_oe;
   logic                  h_scl_low;
   logic                  h_sda_low;
   wire logic             scl_w = ~(h_scl_low | scl_oe);
   wire logic             sda_w = ~(h_sda_low | sda_oe);
   logic                  gpio_one_i;
   byte_t                 evt_second_set;
   int                    fail_count = 0;
   int                    total_checks = 0;
   int                    got;
   i2c_target #(.REV_CODE(REV)) u_dut (
      .mclk(mclk), .rst_n(rst_n), .scl_i(scl_w), .scl_o(), .scl_oe(scl_oe),
      .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe), .gpio_zero_i(gpio_zero_i), .gpio_one_i(gpio_one_i),
      .evt_first_set(evt_first_set), .evt_second_set(evt_second_set), .otp_defaults(otp_defaults),
      .rap_req(rap_req), .rap_done(rap_done), .rap_rdata(rap_rdata), .reg_image(reg_image));
   i2c_host_model u_host (.mclk(mclk), .scl(scl_w), .sda(sda_w), .scl_low(h_scl_low), .sda_low(h_sda_low));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic wr(input byte_t ab, input logic [31:0] data, input int n, input logic ok);
      logic ack;
      u_host.start();
      u_host.send_byte(ab, ack);
      chk(16'(ack), 16'(ok));
      for (int i = 0; i < n; i++) begin
         u_host.send_byte(data[31-8*(i%4) -: 8], ack);
         chk(16'(ack), 16'(ok));
      end
      u_host.stop();
      u_host.tick(4);
   endtask : wr
   task automatic rd(input logic use_off, input byte_t off, input int n, input logic [31:0] exp);
      logic  ack;
      byte_t d;
      u_host.start();
      if (use_off) begin
         u_host.send_byte(8'h7c, ack);
         u_host.send_byte(off, ack);
         chk(16'(ack), 16'h1);
         u_host.start();
      end
      u_host.send_byte(8'h7d, ack);
      chk(16'(ack), 16'h1);
      for (int i = 0; i < n; i++) begin
         u_host.recv_byte(i < n - 1, d);
         chk(16'(d), 16'(exp[31-8*i -: 8]));
      end
      u_host.tick(12);
      chk(16'(sda_oe), 16'h0);
      u_host.stop();
   endtask : rd
   task automatic rap(input logic w, input byte_t a, input byte_t d);
      @(negedge mclk);
      rap_req = '{valid: 1'b1, write: w, addr: a, wdata: d};
      @(negedge mclk);
      rap_req = '0;
      chk(16'(rap_done), 16'h1);
   endtask : rap
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      #500000;
      fail_count++;
      report_and_stop();
   end
   initial begin
      rst_n = 1'b0;
      gpio_zero_i = 1'b1;
      evt_first_set = 8'h00;
      rap_req = '0;
      gpio_one_i = 1'b1;
      evt_second_set = 8'h00;
      for (int i = 0; i < 7; i++) otp_defaults[i] = 8'h10 + 8'(i);
      repeat (2) @(negedge mclk);
      rst_n = 1'b1;
      u_host.tick(4);
      for (int i = 0; i < 7; i++) chk(16'(reg_image[4+i]), 16'(8'h10 + 8'(i)));
      chk(16'(reg_image[IDX_GPIO1]), 16'h0010);
      rd(1'b0, 8'h00, 3, 32'h10000000);
      wr(8'h7c, 32'hb35aa53c, 4, 1'b1);
      chk(16'({reg_image[15], reg_image[16]}), 16'h5aa5);
      chk(16'(reg_image[17]), 16'h003c);
      rd(1'b1, 8'hb3, 2, 32'h5aa50000);
      rd(1'b0, 8'h00, 1, 32'h3c000000);
      img = reg_image;
      wr(8'h7c, 32'hb4000000, 1, 1'b1);
      chk(16'(img === reg_image), 16'h1);
      rd(1'b0, 8'h00, 1, 32'ha5000000);
      wr(8'h7a, 32'hb3110000, 2, 1'b0);
      wr(8'h7f, 32'h0, 0, 1'b0);
      chk(16'(reg_image[15]), 16'h005a);
      wr(8'h7c, 32'hb0ff0000, 2, 1'b1);
      rd(1'b1, 8'hb0, 1, {REV, 24'h0});
      gpio_zero_i = 1'b0;
      rd(1'b1, 8'h00, 1, 32'h0);
      evt_first_set = 8'h81;
      evt_second_set = 8'h42;
      u_host.tick(1);
      evt_first_set = 8'h00;
      evt_second_set = 8'h00;
      u_host.tick(2);
      chk(16'(reg_image[IDX_EVT1]), 16'h0081);
      chk(16'(reg_image[IDX_EVT2]), 16'h0042);
      wr(8'h7c, 32'ha3010000, 2, 1'b1);
      chk(16'(reg_image[IDX_EVT1]), 16'h0080);
      for (int i = 0; i < 7; i++) begin
         got = (i < 4) ? i : i + 3;
         rap(1'b1, 8'h30 + 8'(got), 8'ha0 + 8'(i));
         chk(16'(reg_image[4+i]), 16'(8'ha0 + 8'(i)));
         rap(1'b0, 8'(got), 8'h00);
         chk(16'(rap_rdata), 16'(8'ha0 + 8'(i)));
      end
      rap(1'b1, 8'h10, 8'h77);
      rap(1'b0, 8'h20, 8'h00);
      chk(16'({reg_image[2], rap_rdata}), 16'h7777);
      rap(1'b0, 8'h04, 8'h00);
      chk(16'(rap_rdata), 16'h0000);
      rd(1'b1, 8'h70, 1, 32'ha0000000);
      rap_req = '{valid: 1'b1, write: 1'b1, addr: 8'h00, wdata: 8'h00};
      fork
         wr(8'h7c, 32'hb5b5b5b5, 34, 1'b1);
         begin
            wait (scl_oe === 1'b1);
            @(negedge mclk);
            chk(16'(scl_w), 16'h0);
            chk(16'(reg_image[17]), 16'h003c);
            rap_req = '0;
         end
      join
      chk(16'(scl_oe), 16'h0);
      chk(16'(reg_image[17]), 16'h00b5);
      chk(16'({reg_image[18], reg_image[19]}), 16'hb5b5);
      report_and_stop();
   end
endmodule : tb_i2c_target_register_access
